// [eeprom_pkg.sv]
// Shared constants and types for the two-wire serial EEPROM read path and its controller.
// Assumes a single 125 MHz reference clock on both ends and an open-drain data wire.
//
// How it works
// R1 - Read framing matches write, direction bit high.
// R2 - Address counter holds last access plus one.
// R3 - Read past array end wraps to zero.
// R4 - Write address wraps inside current page.
// R5 - Read address acked, byte shifted MSB first.
// R6 - Single read ends with no-ack then stop.
// R7 - Random read: dummy write, restart, read address.
// R8 - Random read returns byte at loaded address.
// R9 - Controller ack advances counter, next byte follows.
// R10 - Sequential read wraps from array top seamlessly.
// R11 - Controller ends reads with no-ack and stop.
// R12 - Ident page read uses its own type code.
// R13 - Ident reads use offset bits five to zero.
// R14 - Controller stays within the 64-byte ident page.
// R15 - Seal command: ident type, address bit ten set.
// R16 - Seal data needs bit one, others ignored.
// R17 - Sealing makes ident page read-only forever; here the lock flag clears on reset.
// R18 - Program cycle lasts at most 3 ms.
// R19 - Address byte: type, three straps, direction bit.
// R20 - Device acks received bytes in ninth clock.
// R21 - Sealed page leaves ident write data unacked.
// R22 - Device ignores inputs during program cycle.
// R23 - Device releases data in controller ack slot.
// R24 - Device changes data only after falling clock.
package eeprom_pkg;

  // Address byte layout and type codes.
  localparam logic [3:0] TYPE_ARRAY   = 4'hA;
  localparam logic [3:0] TYPE_IDENT   = 4'hB;
  localparam int         TYPE_MSB     = 7;
  localparam int         TYPE_LSB     = 4;
  localparam int         STRAP_MSB    = 3;
  localparam int         STRAP_LSB    = 1;
  localparam int         STRAP_W      = 3;
  localparam int         DIR_POS      = 0;
  localparam logic       DIR_READ     = 1'b1;

  // Memory organisation.
  localparam int ARRAY_ADDR_W = 15;
  localparam int ARRAY_BYTES  = 32768;
  localparam int PAGE_OFS_W   = 6;
  localparam int ID_BYTES     = 64;
  localparam int SEAL_ADDR_POS = 2;  // Bit ten of the address, within the high byte.
  localparam int SEAL_DATA_POS = 1;

  // Bit slot counting: eight data bits then the acknowledge slot.
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam logic [3:0] AFTER_ACK  = 4'h9;

  // Timing.
  localparam int CLK_PERIOD_NS   = 8;
  localparam int CLK_FREQ_KHZ    = 125000;
  localparam int PROG_MAX_NS     = 3000000;
  localparam int PROG_TYP_NS     = 1900000;
  localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;
  localparam int PROG_CNT_W      = $clog2(PROG_MAX_CYCLES + 1);
  localparam int SCL_FREQ_KHZ    = 400;
  localparam int SCL_QUARTER_CYC = (CLK_FREQ_KHZ + 4 * SCL_FREQ_KHZ - 1) / (4 * SCL_FREQ_KHZ);
  localparam int DIV_W           = $clog2(SCL_QUARTER_CYC + 1);

  // Target and controller states.
  typedef enum logic [2:0] {D_IDLE, D_DEV, D_AHI, D_ALO, D_WDATA, D_READ, D_BUSY} dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;
  typedef enum logic [2:0] {S_DEVW, S_AHI, S_ALO, S_DATA, S_DEVR, S_RD} seq_t;

  // One latched controller request.
  typedef struct packed {
    logic        rd;
    logic        rnd;
    logic [3:0]  dtype;
    logic [2:0]  straps;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [6:0]  count;
  } req_t;

endpackage

// [twowire_if.sv]
// Two-wire bus carrier joining the controller end and the EEPROM target end.
// Assumes an ideal pull-up: the data wire is low whenever either end enables its driver.
`timescale 1ns/100ps
interface twowire_if;

  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND of the open-drain drivers with a pull-up.
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport controller (
    output scl,
    output host_sda_oe,
    input  sda
  );

  modport target (
    input  scl,
    input  sda,
    output dev_sda_oe
  );

endinterface // twowire_if

// [bus_sync.sv]
// Two-flop synchroniser and condition detector for the clock and data wires.
// Assumes both wires are asynchronous to i_ref_clk; edges are seen two cycles late.
`timescale 1ns/100ps
module bus_sync (
  // Clock and reset.
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Raw wires.
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Synchronised levels and events.
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_scl_rise,
  output logic      o_scl_fall,
  output logic      o_start,
  output logic      o_stop
);

  logic [1:0] meta;
  logic [1:0] sync;
  logic [1:0] prev;

  // The first stage only feeds the second; edges compare the later stages.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      meta <= 2'h3;
      sync <= 2'h3;
      prev <= 2'h3;
    end
    else
    begin
      meta <= {i_scl, i_sda};
      sync <= meta;
      prev <= sync;
    end
  end

  // Start and stop are data edges while the clock stays high.
  assign o_scl      = sync[1];
  assign o_sda      = sync[0];
  assign o_scl_rise = sync[1] & ~prev[1];
  assign o_scl_fall = ~sync[1] & prev[1];
  assign o_start    = sync[1] & prev[1] & prev[0] & ~sync[0];
  assign o_stop     = sync[1] & prev[1] & ~prev[0] & sync[0];

endmodule // bus_sync

// [eeprom_target.sv]
// Serial EEPROM target: array and identification page reads, writes and page sealing.
// Assumes the controller end drives the clock and obeys the two-wire framing;
// storage is flip-flops and the program cycle is modelled as a busy interval.
`timescale 1ns/100ps
module eeprom_target #(
  parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_MAX_CYCLES
) (
  // Clock and reset.
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst_n,
  // Two-wire bus.
  twowire_if.target                         bus,
  // Strap pins.
  input  wire logic [eeprom_pkg::STRAP_W-1:0] i_chip_select_straps,
  // Status.
  output logic                              o_prog_busy,
  output logic                              o_id_locked
);
  import eeprom_pkg::*;

  logic                    scl_rise;
  logic                    scl_fall;
  logic                    sda;
  logic                    start_det;
  logic                    stop_det;
  dev_state_t              state;
  dev_state_t              next_state;
  logic [3:0]              cnt;
  logic [3:0]              next_cnt;
  logic [7:0]              shreg;
  logic [7:0]              next_shreg;
  logic                    oe;
  logic                    next_oe;
  logic [ARRAY_ADDR_W-1:0] ptr;
  logic [ARRAY_ADDR_W-1:0] next_ptr;
  logic [7:0]              hi;
  logic [7:0]              next_hi;
  logic                    is_id;
  logic                    next_is_id;
  logic                    rw;
  logic                    next_rw;
  logic                    wrote;
  logic                    next_wrote;
  logic                    seal_pend;
  logic                    next_seal_pend;
  logic                    locked;
  logic                    next_locked;
  logic                    prog_busy;
  logic                    next_prog_busy;
  logic [PROG_CNT_W-1:0]   timer;
  logic [PROG_CNT_W-1:0]   next_timer;
  logic [STRAP_W-1:0]      strap_meta;
  logic [STRAP_W-1:0]      straps;
  logic                    mem_we;
  logic                    id_we;
  logic [7:0]              rd_byte;
  logic [7:0]              mem    [ARRAY_BYTES];
  logic [7:0]              id_mem [ID_BYTES];

  // Next address: the array wraps at its top, a page wraps inside itself.
  function automatic logic [ARRAY_ADDR_W-1:0] next_addr(
    input logic [ARRAY_ADDR_W-1:0] a,
    input logic                    page_only
  );
    if (page_only)
      next_addr = {a[ARRAY_ADDR_W-1:PAGE_OFS_W], a[PAGE_OFS_W-1:0] + 6'h01}; // R4 R13
    else
      next_addr = a + 15'h0001; // R3 R10
  endfunction

  bus_sync u_sync (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_scl      (bus.scl),
    .i_sda      (bus.sda),
    .o_scl      (),
    .o_sda      (sda),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start    (start_det),
    .o_stop     (stop_det)
  );

  // Ident page reads use only the low offset bits of the counter.
  assign rd_byte = is_id ? id_mem[ptr[PAGE_OFS_W-1:0]] : mem[ptr]; // R13

  // Protocol engine: all bit moves are keyed to synchronised clock edges.
  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_shreg     = shreg;
    next_oe        = oe;
    next_ptr       = ptr;
    next_hi        = hi;
    next_is_id     = is_id;
    next_rw        = rw;
    next_wrote     = wrote;
    next_seal_pend = seal_pend;
    next_locked    = locked;
    next_prog_busy = prog_busy;
    next_timer     = timer;
    mem_we         = 1'b0;
    id_we          = 1'b0;
    if (state == D_BUSY)
    begin
      // The bus is deaf until the program interval has run out.
      next_oe = 1'b0; // R22
      if (timer == PROG_CNT_W'(PROG_CYCLES - 1)) // R18
      begin
        next_state     = D_IDLE;
        next_prog_busy = 1'b0;
      end
      else
        next_timer = timer + 1'b1;
    end
    else if (stop_det)
    begin
      next_oe    = 1'b0;
      next_state = D_IDLE;
      if (wrote || seal_pend)
      begin
        next_state     = D_BUSY;
        next_prog_busy = 1'b1;
        next_timer     = '0;
        next_locked    = locked | seal_pend; // R17
        next_wrote     = 1'b0;
        next_seal_pend = 1'b0;
      end
    end
    else if (start_det)
    begin
      // A start without a stop abandons any pending program request.
      next_state     = D_DEV;
      next_cnt       = 4'h0;
      next_oe        = 1'b0;
      next_wrote     = 1'b0;
      next_seal_pend = 1'b0;
    end
    else if (state == D_READ)
    begin
      if (scl_rise && cnt < ACK_SLOT)
        next_cnt = cnt + 4'h1;
      else if (scl_rise && cnt == ACK_SLOT)
      begin
        // Counter moves on whether or not the byte was acknowledged.
        next_ptr = next_addr(ptr, is_id); // R2 R9
        next_cnt = AFTER_ACK;
        if (sda)
          next_state = D_IDLE; // R6 R11
      end
      else if (scl_fall && cnt != 4'h0 && cnt < ACK_SLOT)
      begin
        next_shreg = {shreg[6:0], 1'b0};
        next_oe    = ~shreg[6]; // R24
      end
      else if (scl_fall && cnt == ACK_SLOT)
        next_oe = 1'b0; // R23
      else if (scl_fall && cnt == AFTER_ACK)
      begin
        next_shreg = rd_byte; // R9
        next_oe    = ~rd_byte[7]; // R24
        next_cnt   = 4'h0;
      end
    end
    else if (state != D_IDLE)
    begin
      if (scl_rise && cnt < ACK_SLOT)
      begin
        next_shreg = {shreg[6:0], sda};
        next_cnt   = cnt + 4'h1;
      end
      else if (scl_fall && cnt == ACK_SLOT)
      begin
        next_cnt = AFTER_ACK;
        next_oe  = 1'b1; // R20
        case (state)
          D_DEV:
          begin
            if (shreg[STRAP_MSB:STRAP_LSB] != straps ||
                (shreg[TYPE_MSB:TYPE_LSB] != TYPE_ARRAY &&
                 shreg[TYPE_MSB:TYPE_LSB] != TYPE_IDENT)) // R19
            begin
              next_state = D_IDLE;
              next_oe    = 1'b0;
            end
            else
            begin
              next_is_id = (shreg[TYPE_MSB:TYPE_LSB] == TYPE_IDENT); // R12
              next_rw    = shreg[DIR_POS]; // R1
            end
          end
          D_AHI:
            next_hi = shreg;
          D_ALO:
            next_ptr = {hi[ARRAY_ADDR_W-9:0], shreg}; // R7
          D_WDATA:
          begin
            if (is_id && hi[SEAL_ADDR_POS]) // R15
              next_seal_pend = seal_pend | shreg[SEAL_DATA_POS]; // R16
            else if (is_id && locked)
            begin
              next_state = D_IDLE; // R21
              next_oe    = 1'b0;
            end
            else
            begin
              mem_we     = ~is_id;
              id_we      = is_id;
              next_wrote = 1'b1;
              next_ptr   = next_addr(ptr, 1'b1); // R4
            end
          end
          default:
          begin
          end
        endcase
      end
      else if (scl_fall && cnt == AFTER_ACK)
      begin
        next_oe  = 1'b0;
        next_cnt = 4'h0;
        case (state)
          D_DEV:
          begin
            if (rw == DIR_READ)
            begin
              // First byte comes from the counter as it stands.
              next_state = D_READ; // R5 R8
              next_shreg = rd_byte;
              next_oe    = ~rd_byte[7];
            end
            else
              next_state = D_AHI;
          end
          D_AHI:
            next_state = D_ALO;
          D_ALO:
            next_state = D_WDATA;
          default:
          begin
          end
        endcase
      end
    end
  end

  // Control registers; the strap pins pass two flops before use.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state       <= D_IDLE;
      cnt         <= 4'h0;
      shreg       <= 8'h00;
      oe          <= 1'b0;
      ptr         <= '0;
      hi          <= 8'h00;
      is_id       <= 1'b0;
      rw          <= 1'b0;
      wrote       <= 1'b0;
      seal_pend   <= 1'b0;
      locked      <= 1'b0;
      prog_busy   <= 1'b0;
      timer       <= '0;
      strap_meta  <= '0;
      straps      <= '0;
    end
    else
    begin
      state       <= next_state;
      cnt         <= next_cnt;
      shreg       <= next_shreg;
      oe          <= next_oe;
      ptr         <= next_ptr;
      hi          <= next_hi;
      is_id       <= next_is_id;
      rw          <= next_rw;
      wrote       <= next_wrote;
      seal_pend   <= next_seal_pend;
      locked      <= next_locked;
      prog_busy   <= next_prog_busy;
      timer       <= next_timer;
      strap_meta  <= i_chip_select_straps;
      straps      <= strap_meta;
    end
  end

  // Storage is nonvolatile in spirit, so reset leaves its contents alone.
  always_ff @(posedge i_ref_clk)
  begin
    if (mem_we)
      mem[ptr] <= shreg;
    if (id_we)
      id_mem[ptr[PAGE_OFS_W-1:0]] <= shreg;
  end

  assign bus.dev_sda_oe = oe;
  assign o_prog_busy    = prog_busy;
  assign o_id_locked    = locked;

endmodule // eeprom_target

// [twowire_controller.sv]
// Two-wire bus controller: single-byte writes, current and random multi-byte reads.
// Assumes one request at a time; the clock is a divided enable, never a second domain.
`timescale 1ns/100ps
module twowire_controller (
  // Clock and reset.
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rst_n,
  // Two-wire bus.
  twowire_if.controller                       bus,
  // Request.
  input  wire logic                           i_req,
  input  wire logic                           i_read,
  input  wire logic                           i_random,
  input  wire logic [3:0]                     i_dev_type,
  input  wire logic [eeprom_pkg::STRAP_W-1:0] i_straps,
  input  wire logic [15:0]                    i_addr,
  input  wire logic [7:0]                     i_wdata,
  input  wire logic [6:0]                     i_count,
  // Answer.
  output logic                                o_busy,
  output logic [7:0]                          o_rdata,
  output logic                                o_rvalid,
  output logic                                o_nack,
  output logic                                o_done
);
  import eeprom_pkg::*;

  logic        sda;
  host_state_t state, next_state;
  seq_t        seq, next_seq;
  req_t        req, next_req;
  logic [1:0]  q, next_q;
  logic [3:0]  bitn, next_bitn;
  logic [7:0]  shreg, next_shreg;
  logic [6:0]  remain, next_remain;
  logic [DIV_W-1:0] div, next_div;
  logic        scl, next_scl, oe, next_oe, busy, next_busy;
  logic [7:0]  rdata, next_rdata;
  logic        rvalid, next_rvalid, nack, next_nack, done, next_done;
  logic        tick, tx;

  bus_sync u_sync (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_scl      (bus.scl),
    .i_sda      (bus.sda),
    .o_scl      (),
    .o_sda      (sda),
    .o_scl_rise (),
    .o_scl_fall (),
    .o_start    (),
    .o_stop     ()
  );

  assign tick = (state != H_IDLE) && (div == DIV_W'(SCL_QUARTER_CYC - 1));
  assign tx   = (seq != S_RD);

  // Each bit is four quarter periods: set data, raise clock, sample, lower clock.
  always_comb
  begin
    next_state = state; next_seq = seq; next_req = req; next_q = q; next_bitn = bitn;
    next_shreg = shreg; next_remain = remain; next_scl = scl; next_oe = oe;
    next_busy = busy; next_rdata = rdata; next_nack = nack;
    next_rvalid = 1'b0;
    next_done   = 1'b0;
    next_div    = tick ? '0 : div + 1'b1;
    if (tick)
      next_q = q + 2'h1;
    case (state)
      H_IDLE:
      begin
        next_div = '0;
        next_q   = 2'h0;
        if (i_req)
        begin
          next_req    = '{i_read, i_random, i_dev_type, i_straps, i_addr, i_wdata, i_count};
          next_seq    = (i_read && !i_random) ? S_DEVR : S_DEVW; // R7
          next_remain = i_count;
          next_busy   = 1'b1;
          next_nack   = 1'b0;
          next_state  = H_START;
        end
      end
      H_START:
        if (tick)
          case (q)
            2'h0: next_oe = 1'b0;
            2'h1: next_scl = 1'b1;
            2'h2: next_oe = 1'b1;
            default:
            begin
              next_scl   = 1'b0;
              next_state = H_BIT;
              next_bitn  = 4'h0;
              next_shreg = {req.dtype, req.straps, seq == S_DEVR}; // R1 R12 R19
            end
          endcase
      H_BIT:
        if (tick)
          case (q)
            2'h0:
              if (bitn < ACK_SLOT)
                next_oe = tx & ~shreg[7];
              else
                next_oe = ~tx & (remain != 7'h01); // R6 R11 R14
            2'h1: next_scl = 1'b1;
            2'h2:
              if (!tx && bitn < ACK_SLOT)
                next_shreg = {shreg[6:0], sda};
              else if (tx && bitn == ACK_SLOT)
                next_nack = sda;
            default:
            begin
              next_scl = 1'b0;
              if (bitn < ACK_SLOT)
              begin
                next_bitn = bitn + 4'h1;
                if (tx)
                  next_shreg = {shreg[6:0], 1'b0};
              end
              else
              begin
                next_bitn = 4'h0;
                if (tx && nack)
                  next_state = H_STOP;
                else
                  case (seq)
                    S_DEVW: begin next_seq = S_AHI; next_shreg = req.addr[15:8]; end
                    S_AHI:  begin next_seq = S_ALO; next_shreg = req.addr[7:0]; end
                    S_ALO:
                      if (req.rd)
                      begin
                        next_seq   = S_DEVR; // R7
                        next_state = H_START;
                      end
                      else
                      begin
                        next_seq   = S_DATA;
                        next_shreg = req.wdata; // R15 R16
                      end
                    S_DATA: next_state = H_STOP;
                    S_DEVR: next_seq = S_RD;
                    default:
                    begin
                      next_rdata  = shreg;
                      next_rvalid = 1'b1;
                      next_remain = remain - 7'h01;
                      if (remain == 7'h01)
                        next_state = H_STOP; // R11
                    end
                  endcase
              end
            end
          endcase
      H_STOP:
        if (tick)
          case (q)
            2'h0: next_oe = 1'b1;
            2'h1: next_scl = 1'b1;
            2'h2: next_oe = 1'b0;
            default:
            begin
              next_state = H_IDLE;
              next_busy  = 1'b0;
              next_done  = 1'b1;
            end
          endcase
      default: next_state = H_IDLE;
    endcase
  end

  // All bus pins and answers come from registers.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state <= H_IDLE; seq <= S_DEVW; req <= '0; q <= 2'h0; bitn <= 4'h0;
      shreg <= 8'h00; remain <= 7'h00; div <= '0; scl <= 1'b1; oe <= 1'b0;
      busy <= 1'b0; rdata <= 8'h00; rvalid <= 1'b0; nack <= 1'b0; done <= 1'b0;
    end
    else
    begin
      state <= next_state; seq <= next_seq; req <= next_req; q <= next_q;
      bitn <= next_bitn; shreg <= next_shreg; remain <= next_remain; div <= next_div;
      scl <= next_scl; oe <= next_oe; busy <= next_busy; rdata <= next_rdata;
      rvalid <= next_rvalid; nack <= next_nack; done <= next_done;
    end
  end

  assign bus.scl         = scl;
  assign bus.host_sda_oe = oe;
  assign o_busy          = busy;
  assign o_rdata         = rdata;
  assign o_rvalid        = rvalid;
  assign o_nack          = nack;
  assign o_done          = done;

endmodule // twowire_controller

// [twowire_checker.sv]
// Protocol checker for the two-wire link between the controller and the EEPROM target.
// Assumes the target straps are tied to STRAPS for the whole run.
`timescale 1ns/100ps
module twowire_checker #(
  parameter logic [2:0] STRAPS = 3'h0
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Wire signals.
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  import eeprom_pkg::*;
  logic       scl_q, sda_q, dir, in_body, addressed, rd_done;
  logic [3:0] bitcnt;
  logic [1:0] nbyte;
  logic [7:0] sh;
  wire        rise     = scl && !scl_q;
  wire        start    = scl && scl_q && sda_q && !sda;
  wire        ack_rise = rise && bitcnt == ACK_SLOT && in_body;
  wire        addr_ok  = (sh[7:4] == TYPE_ARRAY || sh[7:4] == TYPE_IDENT) && sh[3:1] == STRAPS;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Tracks bit slots from the wire itself; a start restarts framing, as on a real bus.
  always_ff @(posedge i_ref_clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (!i_rst_n || start)
    begin
      bitcnt    <= 4'h0;
      nbyte     <= 2'h0;
      in_body   <= 1'b0;
      addressed <= 1'b0;
      rd_done   <= 1'b0;
    end
    else if (rise)
    begin
      sh     <= {sh[6:0], sda};
      bitcnt <= (bitcnt == ACK_SLOT) ? 4'h0 : bitcnt + 4'h1;
      if (bitcnt == 4'h7 && !in_body)
        dir <= sda;
      if (bitcnt == ACK_SLOT && !in_body)
        addressed <= !sda;
      if (bitcnt == ACK_SLOT)
        in_body <= 1'b1;
      if (ack_rise && nbyte != 2'h3)
        nbyte <= nbyte + 2'h1;
      if (ack_rise && dir && sda)
        rd_done <= 1'b1;
    end
  end

  sequence scl_low4;
    !scl [*4];
  endsequence

  addr_ack_a: assert property (rise && bitcnt == ACK_SLOT && !in_body && dev_sda_oe |-> addr_ok)
    else $error("target acked a foreign address");
  word_ack_a: assert property (ack_rise && !dir && addressed && nbyte < 2'h2 |-> dev_sda_oe)
    else $error("target missed a word address ack");
  rx_quiet_a: assert property (rise && bitcnt != ACK_SLOT && (!dir || !in_body) |-> !dev_sda_oe)
    else $error("target drove data while receiving");
  rd_release_a: assert property (ack_rise && dir |-> !dev_sda_oe)
    else $error("target held data in controller ack slot");
  dev_setup_a: assert property ($changed(dev_sda_oe) |-> scl_low4)
    else $error("target data changed near a clock high phase");
  drive_hold_a: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe [*8])
    else $error("target released data during clock high");
  rd_stop_a: assert property (rd_done |-> !dev_sda_oe)
    else $error("target kept sending after a no-ack");
  own_bus_a: assert property (rise && in_body && dev_sda_oe |-> addressed)
    else $error("unaddressed target drove the bus");
endmodule // twowire_checker

// [serial_eeprom_read_and_id_page_tb.sv]
// Self-checking bench: controller and EEPROM target joined by the two-wire carrier.
// Assumes a short program interval so that polling during it fits a short run.
`timescale 1ns/100ps
module serial_eeprom_read_and_id_page_tb;
  import eeprom_pkg::*;
  localparam int         PROG   = 600;
  localparam logic [2:0] STRAPS = 3'h3;
  logic        i_ref_clk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0, i_read = 1'b0, i_random = 1'b0;
  logic [3:0]  i_dev_type = 4'h0;
  logic [2:0]  i_straps = 3'h0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0]  i_wdata = 8'h00, o_rdata;
  logic [6:0]  i_count = 7'h01;
  logic        o_busy, o_rvalid, o_nack, o_done, o_prog_busy, o_id_locked;
  logic        current_rd = 1'b0;
  logic [7:0]  got[$];
  int          mismatches = 0, cmp_count = 0;

  twowire_if bus_if ();
  twowire_controller u_twowire_controller (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .bus(bus_if), .i_req(i_req), .i_read(i_read), .i_random(i_random),
    .i_dev_type(i_dev_type), .i_straps(i_straps), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_count(i_count), .o_busy(o_busy), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_nack(o_nack), .o_done(o_done));
  eeprom_target #(.PROG_CYCLES(PROG)) u_eeprom_target (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .bus(bus_if), .i_chip_select_straps(STRAPS),
    .o_prog_busy(o_prog_busy), .o_id_locked(o_id_locked));
  twowire_checker #(.STRAPS(STRAPS)) u_twowire_checker (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .scl(bus_if.scl), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe), .sda(bus_if.sda));

  // Free-running reference clock.
  always #(CLK_PERIOD_NS / 2) i_ref_clk = ~i_ref_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One request, held a single cycle; read bytes are gathered until the done pulse.
  task automatic op(input logic rd, input logic [3:0] ty, input logic [2:0] st,
                    input logic [15:0] ad, input logic [7:0] wd, input logic [6:0] n);
    int k;
    got.delete();
    @(negedge i_ref_clk);
    {i_req, i_read, i_random, i_dev_type, i_straps} = {1'b1, rd, rd & ~current_rd, ty, st};
    {i_addr, i_wdata, i_count} = {ad, wd, n};
    @(negedge i_ref_clk);
    i_req = 1'b0;
    chk(8'(o_busy), 8'h01);
    for (k = 0; k < 30000 && o_done !== 1'b1; k++)
    begin
      @(negedge i_ref_clk);
      if (o_rvalid === 1'b1)
        got.push_back(o_rdata);
    end
    if (k == 30000)
    begin
      $display("[ERR] %0t request never finished", $time);
      mismatches++;
      end_sim();
    end
  endtask

  // Waits out the program interval; it must end within the configured length plus 8 cycles.
  task automatic settle();
    int k;
    for (k = 0; k < PROG + 8 && o_prog_busy !== 1'b0; k++)
      @(negedge i_ref_clk);
    chk(8'(k < PROG + 8), 8'h01);
  endtask

  task automatic t_busy();
    op(1'b0, TYPE_ARRAY, STRAPS, 16'h7FFF, 8'h5A, 7'h01);
    chk(8'(o_prog_busy), 8'h01);
    op(1'b1, TYPE_ARRAY, STRAPS, 16'h7FFF, 8'h00, 7'h01);
    chk(8'(o_nack), 8'h01);
    settle();
  endtask

  task automatic t_wrap();
    op(1'b0, TYPE_ARRAY, STRAPS, 16'h0000, 8'hA5, 7'h01);
    settle();
    op(1'b1, TYPE_ARRAY, STRAPS, 16'h7FFF, 8'h00, 7'h02);
    chk(8'(got.size()), 8'h02);
    chk(got[0], 8'h5A);
    chk(got[1], 8'hA5);
    chk(8'(o_nack), 8'h00);
  endtask

  task automatic t_straps();
    op(1'b1, TYPE_ARRAY, ~STRAPS, 16'h0000, 8'h00, 7'h01);
    chk(8'(o_nack), 8'h01);
    chk(8'(got.size()), 8'h00);
  endtask

  // Offset 0x3F reached through high address bits that must be ignored.
  task automatic t_seal();
    op(1'b0, TYPE_IDENT, STRAPS, 16'hFB3F, 8'hC3, 7'h01);
    settle();
    op(1'b0, TYPE_IDENT, STRAPS, 16'h0400, 8'hF2, 7'h01);
    settle();
    chk(8'(o_id_locked), 8'h01);
    op(1'b0, TYPE_IDENT, STRAPS, 16'h003F, 8'h00, 7'h01);
    chk(8'(o_nack), 8'h01);
    settle();
    current_rd = 1'b1;
    op(1'b1, TYPE_IDENT, STRAPS, 16'h0000, 8'h00, 7'h01);
    current_rd = 1'b0;
    chk(got[0], 8'hC3);
    op(1'b1, TYPE_IDENT, STRAPS, 16'hFF7F, 8'h00, 7'h01);
    chk(got[0], 8'hC3);
  endtask

  initial
  begin
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    t_busy();
    t_wrap();
    t_straps();
    t_seal();
    end_sim();
  end
endmodule // serial_eeprom_read_and_id_page_tb
